// File: dv/gpio_far_end.sv
// Device on the pad side: drives undriven pads, reads driven ones.
// Assumes the bench never enables its drive on a pad the block drives.
`timescale 1ns/1ps
`default_nettype none
module gpio_far_end #(
  parameter int N = 10
) (
  input wire logic mclk,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] ext_val,
  input wire logic [N-1:0] ext_en,
  output logic [N-1:0] pad_in
);
  logic [N-1:0] last_r = '0;
  always_ff @(posedge mclk) last_r <= pad_in;
  // Floating pads flip each cycle rather than keep a stale level
  assign pad_in = (pad_oe & pad_out)
    | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & ~last_r);
endmodule
`default_nettype wire

// File: dv/gpio_with_alarm_output_chk.sv
// Port-level checker for the pad block, bound into its top module.
// Assumes a single clock and raw active-low reset at the ports.
`timescale 1ns/1ps
`default_nettype none
module gpio_with_alarm_output_chk #(
  parameter int NUM_PADS = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_PADS-1:0] pad_in,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] pad_out,
  input wire logic alarm_start,
  input wire logic alarm_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire rd = req && !wb_we_i;
  wire clr = wr && wb_adr_i == gpio_pkg::OFS_ALARM && wb_sel_i[0]
    && wb_dat_i[0] && !wb_dat_i[1];
  wire [31:0] smask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  logic [31:0] shadow_r;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) shadow_r <= '0;
    else if (wr && wb_adr_i == gpio_pkg::OFS_OUT)
      shadow_r <= (shadow_r & ~smask) | (wb_dat_i & smask);
  property p_ack_resp; req |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("no ack after request");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  property p_alarm_rise; alarm_start |=> alarm_active; endproperty
  a_alarm_rise: assert property (p_alarm_rise)
    else $error("alarm did not rise");
  property p_alarm_hold; alarm_active && !clr |=> alarm_active; endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm fell without clear");
  property p_alarm_clr; clr && !alarm_start |=> !alarm_active;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr)
    else $error("alarm not cleared");
  property p_in_read;
    rd && wb_adr_i == gpio_pkg::OFS_IN |=> (wb_dat_o[NUM_PADS-1:0]
      & ~$past(pad_oe)) == ($past(pad_in, 2) & ~$past(pad_oe));
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input read mismatch");
  property p_out_read; rd && wb_adr_i == gpio_pkg::OFS_OUT
    |=> wb_dat_o[NUM_PADS-1:0] == shadow_r[NUM_PADS-1:0]; endproperty
  a_out_read: assert property (p_out_read)
    else $error("output query mismatch");
  property p_rd_unm; rd && wb_adr_i >= 8'h14 |=> wb_dat_o == '0;
  endproperty
  a_rd_unm: assert property (p_rd_unm)
    else $error("unmapped read not zero");
  c_clear: cover property (clr && alarm_active);
  c_in: cover property (rd && wb_adr_i == gpio_pkg::OFS_IN);
  c_buzz: cover property ($rose(pad_out[gpio_pkg::BUZZ_PAD]));
endmodule
bind gpio_with_alarm_output gpio_with_alarm_output_chk #(
  .NUM_PADS(NUM_PADS)) u_chk (.mclk(mclk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in),
  .pad_oe(pad_oe), .pad_out(pad_out), .alarm_start(alarm_start),
  .alarm_active(alarm_active));
`default_nettype wire

// File: dv/tb_gpio_with_alarm_output.sv
// Self-checking bench for the pad block, one task per scenario.
// Assumes package, design, checker and far-end model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_with_alarm_output;
  logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, rf = 0, ast = 0;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, q, dat_o;
  logic [3:0] sel = 0;
  logic [9:0] pin, pout, poe, ev = 0, ee = 0;
  logic ack, alm;
  int err_count = 0, total_checks = 0, n;
  initial forever #12.5 mclk = ~mclk;
  gpio_with_alarm_output u_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .pad_in(pin),
    .pad_out(pout), .pad_oe(poe), .rf_transmit_indicator(rf),
    .alarm_start(ast), .alarm_active(alm));
  gpio_far_end u_far (.mclk(mclk), .pad_out(pout), .pad_oe(poe),
    .ext_val(ev), .ext_en(ee), .pad_in(pin));
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin @(posedge mclk); end while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic st(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic gapw;
    logic b;
    b = pout[7];
    n = 0;
    do begin st(1); n++; end while (pout[7] === b && n < 300);
  endtask
  task automatic t_reset;
    chk("oe", 0, poe);
    bus(0, gpio_pkg::OFS_MODE, 0);
    chk("mode", gpio_pkg::MODE_RST, q);
    bus(0, 8'h20, 0);
    chk("unmapped", 0, q);
  endtask
  task automatic t_input;
    @(posedge mclk);
    {ee, ev} <= {10'h3FF, 10'h2C9};
    st(3);
    bus(0, gpio_pkg::OFS_IN, 0);
    chk("in", 32'h0000_02C9, q);
  endtask
  task automatic t_output;
    bus(1, gpio_pkg::OFS_MODE, 32'h0005_5555);
    ee <= '0;
    bus(1, gpio_pkg::OFS_OUT, 32'h0000_02A5);
    st(2);
    chk("oe", 10'h3FF, poe);
    chk("wire", 10'h2A5, pin);
    bus(0, gpio_pkg::OFS_OUT, 0);
    chk("query", 32'h0000_02A5, q);
    bus(0, gpio_pkg::OFS_IN, 0);
    chk("in_masked", 0, q);
  endtask
  task automatic t_alt;
    bus(1, gpio_pkg::OFS_MODE, 32'h0005_A956);
    bus(0, gpio_pkg::OFS_MODE, 0);
    chk("mode", 32'h0005_A955, q);
    bus(1, gpio_pkg::OFS_OUT, 32'h0000_00E0);
    st(2);
    chk("alt_out", 0, pout);
    @(posedge mclk);
    rf <= 1;
    st(3);
    chk("rf", 1, pout[5]);
    @(posedge mclk);
    rf <= 0;
  endtask
  task automatic t_alarm;
    @(posedge mclk);
    ast <= 1;
    @(posedge mclk);
    ast <= 0;
    st(22);
    chk("alarm", 1, {alm, pout[6]} == 2'b11);
    bus(1, gpio_pkg::OFS_ALARM, 1);
    st(3);
    chk("cleared", 0, {alm, pout[6]});
    bus(1, gpio_pkg::OFS_ALARM, 2);
    bus(0, gpio_pkg::OFS_ALARM, 0);
    chk("alarm_sw", 1, q);
    bus(1, gpio_pkg::OFS_ALARM, 1);
    bus(0, gpio_pkg::OFS_ALARM, 0);
    chk("alarm_clr", 0, q);
  endtask
  task automatic t_buzz;
    bus(1, gpio_pkg::OFS_TONE, 32'h8000_0001);
    st(1);
    gapw;
    gapw;
    chk("half", 40, n);
    bus(1, gpio_pkg::OFS_TONE, 0);
    st(3);
    chk("quiet", 0, pout[7]);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    st(4);
    t_reset;
    t_input;
    t_output;
    t_alt;
    t_alarm;
    t_buzz;
    print_verdict;
  end
  initial begin
    #100000;
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire

// File: hdl/gpio_pad_cell.sv
// One pad's output stage: picks user or function level and drive enable.
// Assumes mode has already been checked as legal for this pad.
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_cell (
  input wire logic mclk,
  input wire logic rst_n,
  input wire gpio_pkg::pad_mode_e mode,
  input wire logic user_val,
  input wire logic func_val,
  output gpio_pkg::pad_drive_s drive
);

  wire gpio_pkg::pad_drive_s drive_nxt;

  // Output and function modes drive both levels actively
  assign drive_nxt.oe = (mode == gpio_pkg::MODE_OUT) ||
                        (mode == gpio_pkg::MODE_ALT);
  // Function logic, not the user value, steers an alternate pad
  assign drive_nxt.out = (mode == gpio_pkg::MODE_ALT) ? func_val :
                         (mode == gpio_pkg::MODE_OUT) ? user_val :
                         1'b0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drive <= '0;
    end else begin
      drive <= drive_nxt;
    end
  end

endmodule
`default_nettype wire

// File: hdl/gpio_pkg.sv
// Constants, mode codes and carrier types for the general purpose pad block.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
package gpio_pkg;

  localparam int NUM_PADS_DEF = 10;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_IN = 8'h08;
  localparam logic [7:0] OFS_ALARM = 8'h0C;
  localparam logic [7:0] OFS_TONE = 8'h10;

  // Reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_RST = 32'h0000_0000;
  localparam logic [31:0] TONE_RST = 32'h0000_0000;

  // Pads that carry an alternate function
  localparam int RF_PAD = 5;
  localparam int ALARM_PAD = 6;
  localparam int BUZZ_PAD = 7;

  // Field positions
  localparam int MODE_FLD_W = 2;
  localparam int ALARM_CLR_BIT = 0;
  localparam int ALARM_SET_BIT = 1;
  localparam int ALARM_STATE_BIT = 0;
  localparam int TONE_HALF_W = 16;
  localparam int TONE_EN_BIT = 31;

  // Buzzer time base: one tick per microsecond
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * 1000 + CLK_PERIOD_PS - 1)
                            / CLK_PERIOD_PS;
  localparam int TICK_CNT_W = 6;

  typedef enum logic [1:0] {
    MODE_IN  = 2'b00,
    MODE_OUT = 2'b01,
    MODE_ALT = 2'b10
  } pad_mode_e;

  typedef struct packed {
    logic oe;
    logic out;
  } pad_drive_s;

endpackage

// File: hdl/gpio_with_alarm_output.sv
// General purpose pad block with alarm, buzzer and RF monitor functions.
// Assumes pad inputs, alarm_start and the RF indicator are synchronous.
//
// Behaviour
// - Each pad takes one of three modes: input, output or alternate.
// - Input pads are only read and return the pad level sampled one cycle earlier.
// - Output pads are written or queried; written value sets driven level.
// - Alternate pads are driven by internal function logic, not user value.
// - Alternate functions: RF monitor, alarm, buzzer; others in or out only.
// - Output pads use push-pull drive, both levels actively driven.
// - Alarm pad rises when alarm starts, stays high until clear command.
// - Buzzer pad in alternate mode drives square waves for tones.
`timescale 1ns/1ps
`default_nettype none
module gpio_with_alarm_output #(
  parameter int NUM_PADS = gpio_pkg::NUM_PADS_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gpio_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [gpio_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [gpio_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe,
  input wire logic rf_transmit_indicator,
  input wire logic alarm_start,
  output logic alarm_active
);

  localparam int MODE_W = NUM_PADS * gpio_pkg::MODE_FLD_W;

  // Reset synchroniser
  // Everything stays in reset for two edges after rst_n rises
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_int_n = rst_sync_r;

  // Bus decode
  logic ack_r;
  logic [gpio_pkg::DAT_W-1:0] rdata_r;
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  // Writes land at the edge where the master samples ack high
  wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  wire bus_rd = bus_req && !wb_we_i;
  wire sel_mode = (wb_adr_i == gpio_pkg::OFS_MODE);
  wire sel_out = (wb_adr_i == gpio_pkg::OFS_OUT);
  wire sel_in = (wb_adr_i == gpio_pkg::OFS_IN);
  wire sel_alarm = (wb_adr_i == gpio_pkg::OFS_ALARM);
  wire sel_tone = (wb_adr_i == gpio_pkg::OFS_TONE);
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Registers
  logic [MODE_W-1:0] mode_r;
  logic [MODE_W-1:0] mode_nxt;
  logic [NUM_PADS-1:0] out_r;
  logic [NUM_PADS-1:0] in_r;
  logic [31:0] tone_r;
  logic alarm_r;

  wire [31:0] mode_word = 32'(mode_r);
  wire [31:0] mode_wdat = (wb_dat_i & byte_mask) | (mode_word & ~byte_mask);
  wire [31:0] out_word = 32'(out_r);
  wire [31:0] out_wdat = (wb_dat_i & byte_mask) | (out_word & ~byte_mask);
  wire [31:0] tone_wdat = (wb_dat_i & byte_mask) | (tone_r & ~byte_mask);
  wire mode_wr = bus_wr && sel_mode;
  wire out_wr = bus_wr && sel_out;
  wire tone_wr = bus_wr && sel_tone;

  // Per-pad mode legality and input masking
  logic [NUM_PADS-1:0] pad_is_in;
  logic [NUM_PADS-1:0] func_val;
  logic buzz_r;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PADS; gi = gi + 1) begin : g_pad
      localparam bit HAS_ALT = (gi == gpio_pkg::RF_PAD) ||
                               (gi == gpio_pkg::ALARM_PAD) ||
                               (gi == gpio_pkg::BUZZ_PAD);
      wire [1:0] req_mode = mode_wdat[gi*2 +: 2];
      wire [1:0] cur_mode = mode_r[gi*2 +: 2];
      // Only the three function pads accept the alternate code
      wire legal = (req_mode == gpio_pkg::MODE_IN) ||
                   (req_mode == gpio_pkg::MODE_OUT) ||
                   ((req_mode == gpio_pkg::MODE_ALT) && HAS_ALT);
      gpio_pkg::pad_drive_s drv;

      // An illegal field keeps its pad's mode; other fields still update
      assign mode_nxt[gi*2 +: 2] = (mode_wr && legal) ? req_mode : cur_mode;
      assign pad_is_in[gi] = (cur_mode == gpio_pkg::MODE_IN);

      if (gi == gpio_pkg::RF_PAD) begin : g_rf
        assign func_val[gi] = rf_transmit_indicator;
      end else if (gi == gpio_pkg::ALARM_PAD) begin : g_alarm
        assign func_val[gi] = alarm_r;
      end else if (gi == gpio_pkg::BUZZ_PAD) begin : g_buzz
        assign func_val[gi] = buzz_r;
      end else begin : g_none
        // Pads without a function see a constant low
        assign func_val[gi] = 1'b0;
      end

      // The pad cell adds one register stage to every source
      gpio_pad_cell u_cell (
        .mclk(mclk),
        .rst_n(rst_int_n),
        .mode(gpio_pkg::pad_mode_e'(cur_mode)),
        .user_val(out_r[gi]),
        .func_val(func_val[gi]),
        .drive(drv)
      );
      assign pad_out[gi] = drv.out;
      assign pad_oe[gi] = drv.oe;
    end
  endgenerate

  // Alarm: start beats a clear landing in the same cycle
  wire alarm_wr = bus_wr && sel_alarm && wb_sel_i[0];
  wire alarm_clr = alarm_wr && wb_dat_i[gpio_pkg::ALARM_CLR_BIT];
  wire alarm_sw_set = alarm_wr && wb_dat_i[gpio_pkg::ALARM_SET_BIT];
  wire alarm_set = alarm_start || alarm_sw_set;
  wire alarm_nxt = alarm_set ? 1'b1 : (alarm_clr ? 1'b0 : alarm_r);
  assign alarm_active = alarm_r;

  // Read multiplexer; unmapped addresses read zero
  wire [31:0] in_word = 32'(in_r & pad_is_in);
  wire [31:0] alarm_word = {31'h0000_0000, alarm_r};
  wire [31:0] rd_mux = sel_mode ? mode_word :
                       sel_out ? out_word :
                       sel_in ? in_word :
                       sel_alarm ? alarm_word :
                       sel_tone ? tone_r : 32'h0000_0000;

  // Read data is captured when taken and held until the next read
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      if (bus_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mode_r <= gpio_pkg::MODE_RST[MODE_W-1:0];
      out_r <= gpio_pkg::OUT_RST[NUM_PADS-1:0];
      tone_r <= gpio_pkg::TONE_RST;
      alarm_r <= 1'b0;
      in_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      // Pads are sampled every cycle; IN reads the previous cycle
      in_r <= pad_in;
      alarm_r <= alarm_nxt;
      if (out_wr) begin
        out_r <= out_wdat[NUM_PADS-1:0];
      end
      if (tone_wr) begin
        tone_r <= tone_wdat;
      end
    end
  end

  // Buzzer square wave: microsecond tick, half period in ticks
  // A half period of zero behaves as one tick
  logic [gpio_pkg::TICK_CNT_W-1:0] tick_cnt_r;
  logic [gpio_pkg::TONE_HALF_W-1:0] half_cnt_r;
  localparam logic [gpio_pkg::TICK_CNT_W-1:0] TICK_LAST =
    gpio_pkg::TICK_CNT_W'(gpio_pkg::TICK_CYC - 1);
  wire tone_en = tone_r[gpio_pkg::TONE_EN_BIT];
  wire [gpio_pkg::TONE_HALF_W-1:0] half_set =
    tone_r[gpio_pkg::TONE_HALF_W-1:0];
  wire tick = (tick_cnt_r == TICK_LAST);
  wire half_done = (half_cnt_r + 16'h0001 >= half_set);

  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tick_cnt_r <= '0;
      half_cnt_r <= '0;
      buzz_r <= 1'b0;
    end else if (!tone_en) begin
      // Disabling parks the buzzer low and restarts its counters
      tick_cnt_r <= '0;
      half_cnt_r <= '0;
      buzz_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
      if (tick) begin
        if (half_done) begin
          half_cnt_r <= '0;
          buzz_r <= !buzz_r;
        end else begin
          half_cnt_r <= half_cnt_r + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire
